// [design/sbit_defines.svh]
// constants for the sdram burst interrupt and masking core
// assumes the includer uses them at the widths given here
`ifndef SBIT_DEFINES_SVH
`define SBIT_DEFINES_SVH
`define SBIT_COL_W        8
`define SBIT_PAGE_MASK    8'hff
`define SBIT_ADDR_BANK    9
`define SBIT_ADDR_ALLBANK 8
`define SBIT_ADDR_AUTOPRE 8
`define SBIT_MEM_WORDS    512
`endif

// [design/sbit_pkg.sv]
// types shared by the sdram burst interrupt and masking core
// assumes nothing beyond a systemverilog compiler
package sbit_pkg;
  typedef enum logic [1:0] {BURST_IDLE, BURST_READ, BURST_WRITE} sbit_burst_e;
  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE,
                            CMD_PRE, CMD_STOP} sbit_cmd_e;
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } sbit_cmd_s;
  typedef struct packed {
    logic upperByteMask;
    logic lowerByteMask;
  } sbit_mask_s;
  typedef struct packed {
    logic       casLat3;
    logic       fullPage;
    logic [1:0] burstLenLog;
    logic       singleWrite;
  } sbit_mode_s;

  function automatic sbit_cmd_e decodeCmd(input sbit_cmd_s p);
    sbit_cmd_e c;
    c = CMD_NOP;
    if (!p.csN) begin
      case ({p.rasN, p.casN, p.weN})
        3'h3:    c = CMD_ACT;
        3'h5:    c = CMD_READ;
        3'h4:    c = CMD_WRITE;
        3'h2:    c = CMD_PRE;
        3'h6:    c = CMD_STOP;
        default: c = CMD_NOP;
      endcase
    end
    return c;
  endfunction : decodeCmd
endpackage : sbit_pkg

// [design/sbit_core.sv]
// sdram burst control: precharge and burst-stop interrupts, byte masking,
// burst-read/single-write, clock suspend, over a one-page-per-bank store
// assumes command pins are driven from the same clk by the controller
// What this block does
// - read precharge: output lasts CAS-latency minus one cycles
// - write precharge stops storing that cycle
// - other-bank precharge never interrupts the write
// - full-page read wraps to start after 256
// - full-page write wraps to start after 256
// - read burst stop: output lasts CAS-latency minus one cycles
// - write burst stop ends write immediately
// - read mask floats byte two cycles later
// - upper and lower masks act per byte
// - read mask gates drivers, counter keeps running
// - write mask drops byte with no latency
// - write mask gates input, counter keeps running
// - single-write mode stores one word per write
// - clock enable low suspends and freezes state
// - clock enable high resumes next edge
// - all-banks bit precharges both, else bank bit
// - full page spans 256 columns
`timescale 1ns/10ps
`include "sbit_defines.svh"
module sbit_core (
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic                 cke,
  input  wire sbit_pkg::sbit_cmd_s  cmdPins,
  input  wire logic [9:0]           addr,
  input  wire sbit_pkg::sbit_mask_s byteMaskPair,
  input  wire sbit_pkg::sbit_mode_s mode,
  input  wire logic [15:0]          dqIn,
  output logic [15:0]               dqOut,
  output logic [1:0]                dqOe,
  output logic [1:0]                bankOpen,
  output logic                      suspended,
  output sbit_pkg::sbit_burst_e     burstKind
);
  logic                  ckePrev_reg;
  logic                  suspended_reg;
  sbit_pkg::sbit_burst_e burst_reg;
  logic                  bank_reg;
  logic                  autoPre_reg;
  logic [7:0]            start_reg;
  logic [7:0]            off_reg;
  logic [7:0]            left_reg;
  logic [1:0]            bankOpen_reg;
  logic [1:0]            maskDly_reg;
  logic [2:0]            rdV_reg;
  logic [15:0]           rdD_reg [3];
  logic [15:0]           dqOut_reg;
  logic [1:0]            dqOe_reg;
  logic [15:0]           mem [`SBIT_MEM_WORDS];

  logic                  en;
  sbit_pkg::sbit_cmd_e   cmd;
  logic                  newCol;
  logic                  preHit;
  logic                  stopNow;
  logic [7:0]            len;
  logic [7:0]            lenMask;
  logic [7:0]            curCol;
  sbit_pkg::sbit_burst_e accKind;
  logic [7:0]            accCol;
  logic                  accBank;
  logic                  memWe;
  logic [1:0]            memWeByte;
  logic                  burstEnd;

  // sequential order wraps inside the burst-length block
  function automatic logic [7:0] colAt(input logic [7:0] s, input logic [7:0] o,
                                       input logic [7:0] m);
    colAt = (s & ~m) | (8'(s + o) & m);
  endfunction : colAt

  // suspend takes effect one edge after cke moves, both ways
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ckePrev_reg   <= 1'b0;
      suspended_reg <= 1'b1;
    end else begin
      ckePrev_reg   <= cke;
      suspended_reg <= !cke;
    end
  end

  assign en      = ckePrev_reg;
  assign cmd     = en ? sbit_pkg::decodeCmd(cmdPins) : sbit_pkg::CMD_NOP;
  assign newCol  = (cmd == sbit_pkg::CMD_READ) || (cmd == sbit_pkg::CMD_WRITE);
  // a precharge only interrupts the burst of the bank it closes
  assign preHit  = (cmd == sbit_pkg::CMD_PRE) && (burst_reg != sbit_pkg::BURST_IDLE) &&
                   (addr[`SBIT_ADDR_ALLBANK] || (addr[`SBIT_ADDR_BANK] == bank_reg));
  assign stopNow = preHit || (cmd == sbit_pkg::CMD_STOP);
  assign len     = 8'h01 << mode.burstLenLog;
  assign lenMask = mode.fullPage ? `SBIT_PAGE_MASK : 8'(len - 8'h01);
  assign curCol  = colAt(start_reg, off_reg, lenMask);

  always_comb begin
    accKind = sbit_pkg::BURST_IDLE;
    accCol  = curCol;
    accBank = bank_reg;
    if (newCol) begin
      accKind = (cmd == sbit_pkg::CMD_READ) ? sbit_pkg::BURST_READ : sbit_pkg::BURST_WRITE;
      accCol  = addr[7:0];
      accBank = addr[`SBIT_ADDR_BANK];
    end else if (en && !stopNow) begin
      accKind = burst_reg;
    end
  end

  assign memWe     = en && (accKind == sbit_pkg::BURST_WRITE);
  assign memWeByte = {2{memWe}} & ~byteMaskPair;
  assign burstEnd  = en && !newCol && !stopNow && (burst_reg != sbit_pkg::BURST_IDLE) &&
                     !mode.fullPage && (left_reg == 8'h01);

  // burst sequencer; masks never reach it, so columns advance regardless
  always_ff @(posedge clk) begin
    if (!rstn) begin
      burst_reg   <= sbit_pkg::BURST_IDLE;
      bank_reg    <= 1'b0;
      autoPre_reg <= 1'b0;
      start_reg   <= 8'h00;
      off_reg     <= 8'h00;
      left_reg    <= 8'h00;
    end else if (en) begin
      if (newCol) begin
        start_reg   <= addr[7:0];
        bank_reg    <= addr[`SBIT_ADDR_BANK];
        autoPre_reg <= addr[`SBIT_ADDR_AUTOPRE] && !mode.fullPage;
        off_reg     <= 8'h01;
        if (accKind == sbit_pkg::BURST_WRITE && mode.singleWrite) begin
          burst_reg <= sbit_pkg::BURST_IDLE;
          left_reg  <= 8'h00;
        end else begin
          burst_reg <= (!mode.fullPage && len == 8'h01) ? sbit_pkg::BURST_IDLE : accKind;
          left_reg  <= 8'(len - 8'h01);
        end
      end else if (stopNow) begin
        burst_reg <= sbit_pkg::BURST_IDLE;
      end else if (burst_reg != sbit_pkg::BURST_IDLE) begin
        off_reg  <= 8'(off_reg + 8'h01);
        left_reg <= 8'(left_reg - 8'h01);
        if (burstEnd) begin
          burst_reg <= sbit_pkg::BURST_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bankOpen_reg <= 2'h0;
    end else if (en) begin
      if (cmd == sbit_pkg::CMD_ACT) begin
        bankOpen_reg[addr[`SBIT_ADDR_BANK]] <= 1'b1;
      end else if (cmd == sbit_pkg::CMD_PRE && addr[`SBIT_ADDR_ALLBANK]) begin
        bankOpen_reg <= 2'h0;
      end else if (cmd == sbit_pkg::CMD_PRE) begin
        bankOpen_reg[addr[`SBIT_ADDR_BANK]] <= 1'b0;
      end else if (burstEnd && autoPre_reg) begin
        bankOpen_reg[bank_reg] <= 1'b0;
      end
    end
  end

  // store keeps one page per bank; the row address is not modelled
  always_ff @(posedge clk) begin
    if (memWeByte[0]) begin
      mem[{accBank, accCol}][7:0] <= dqIn[7:0];
    end
    if (memWeByte[1]) begin
      mem[{accBank, accCol}][15:8] <= dqIn[15:8];
    end
  end

  // read pipe: stage index picks the cas latency at the pins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdV_reg    <= 3'h0;
      rdD_reg[0] <= 16'h0000;
      rdD_reg[1] <= 16'h0000;
      rdD_reg[2] <= 16'h0000;
    end else if (en) begin
      rdV_reg    <= {rdV_reg[1:0], accKind == sbit_pkg::BURST_READ};
      rdD_reg[0] <= mem[{accBank, accCol}];
      rdD_reg[1] <= rdD_reg[0];
      rdD_reg[2] <= rdD_reg[1];
    end
  end

  // mask delay stage plus output stage gives the fixed two-cycle float
  always_ff @(posedge clk) begin
    if (!rstn) begin
      maskDly_reg <= 2'h0;
      dqOut_reg   <= 16'h0000;
      dqOe_reg    <= 2'h0;
    end else if (en) begin
      maskDly_reg <= byteMaskPair;
      dqOut_reg   <= mode.casLat3 ? rdD_reg[1] : rdD_reg[0];
      dqOe_reg    <= {2{mode.casLat3 ? rdV_reg[1] : rdV_reg[0]}} & ~maskDly_reg;
    end
  end

  assign dqOut     = dqOut_reg;
  assign dqOe      = dqOe_reg;
  assign bankOpen  = bankOpen_reg;
  assign suspended = suspended_reg;
  assign burstKind = burst_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic rdPre;
  assign rdPre = en && preHit && (burst_reg == sbit_pkg::BURST_READ);

  AST_RD_PRE_CL2: assert property (
    rdPre && !mode.casLat3 ##1 en |=> dqOe == 2'h0)
    else $error("read output ran past cas latency 2 after precharge");
  AST_RD_PRE_CL3: assert property (
    rdPre && mode.casLat3 && rdV_reg[0] && maskDly_reg == 2'h0 && byteMaskPair == 2'h0
    ##1 en |=> dqOe == 2'h3 ##1 en ##1 dqOe == 2'h0)
    else $error("read output tail wrong at cas latency 3 after precharge");
  AST_RD_STOP_CL2: assert property (
    en && cmd == sbit_pkg::CMD_STOP && burst_reg == sbit_pkg::BURST_READ && !mode.casLat3
    ##1 en |=> dqOe == 2'h0)
    else $error("read output still driven after burst stop");
  AST_WR_PRE_NOSTORE: assert property (
    en && preHit && burst_reg == sbit_pkg::BURST_WRITE |-> memWeByte == 2'h0)
    else $error("write stored in precharge cycle");
  AST_PRE_OTHER_BANK: assert property (
    en && cmd == sbit_pkg::CMD_PRE && !addr[`SBIT_ADDR_ALLBANK] &&
    addr[`SBIT_ADDR_BANK] != bank_reg && burst_reg == sbit_pkg::BURST_WRITE |-> memWe)
    else $error("other-bank precharge broke the write burst");
  AST_FULLPAGE_WRAP: assert property (
    en && mode.fullPage && burst_reg != sbit_pkg::BURST_IDLE && !newCol && !stopNow &&
    off_reg == 8'hff |=> curCol == start_reg)
    else $error("full page burst did not wrap to start column");
  AST_WR_STOP: assert property (
    en && cmd == sbit_pkg::CMD_STOP |=> burst_reg == sbit_pkg::BURST_IDLE && !memWe)
    else $error("write went on after burst stop");
  AST_RD_MASK_HI: assert property (
    en && byteMaskPair.upperByteMask ##1 en |=> !dqOe[1])
    else $error("upper byte driven two cycles after its mask");
  AST_RD_MASK_COUNT: assert property (
    en && burst_reg != sbit_pkg::BURST_IDLE && byteMaskPair == 2'h3 && !newCol &&
    !stopNow |=> off_reg == 8'($past(off_reg) + 8'h01))
    else $error("burst counter stalled under mask");
  AST_SINGLE_WR: assert property (
    en && cmd == sbit_pkg::CMD_WRITE && mode.singleWrite |=> burst_reg != sbit_pkg::BURST_WRITE)
    else $error("single-write mode stored more than one word");
  AST_SUSPEND_HOLD: assert property (
    !en |=> $stable(dqOut) && $stable(dqOe) && $stable(off_reg) && $stable(burst_reg))
    else $error("state moved during clock suspend");
  AST_RESUME: assert property (
    !en && cke |=> en && !suspended)
    else $error("suspend not left on next edge");
  AST_PRE_ALL: assert property (
    en && cmd == sbit_pkg::CMD_PRE && addr[`SBIT_ADDR_ALLBANK] |=> bankOpen == 2'h0)
    else $error("all-bank precharge left a bank open");

  COV_WRAP: cover property (en && mode.fullPage && off_reg == 8'hff ##1 curCol == start_reg);
  COV_RD_PRE: cover property (rdPre ##1 en ##1 en);
  COV_SUSPEND: cover property (burst_reg != sbit_pkg::BURST_IDLE && !en ##1 en);
  COV_WR_MASK: cover property (memWe && memWeByte == 2'h1);
endmodule : sbit_core

// [verif/sbit_ctrl_model.sv]
// controller stand-in: drives command, address, byte masks, write data and cke
// assumes its tasks are called 1 ns after a rising edge of clk
`timescale 1ns/10ps
module sbit_ctrl_model (
  input  wire logic            clk,
  output sbit_pkg::sbit_cmd_s  cmdPins,
  output logic [9:0]           addr,
  output sbit_pkg::sbit_mask_s byteMaskPair,
  output logic [15:0]          dqIn,
  output logic                 cke
);
  initial begin
    cmdPins = 4'hf;
    addr = 10'h000;
    byteMaskPair = 2'h0;
    dqIn = 16'h0000;
    cke = 1'b1;
  end

  // one command per edge; an undriven data bus flips so stale data never looks valid
  // masks are taken as given: only a write-interrupting precharge must carry both high
  task automatic send(input logic [3:0] c, input logic [9:0] a, input logic [1:0] m,
                      input logic [15:0] d, input logic drv);
    cmdPins = c;
    addr = a;
    byteMaskPair = m;
    dqIn = drv ? d : ~dqIn;
    @(posedge clk);
    #1;
  endtask : send

  // suspends stay a few cycles, far inside the refresh period; nops follow resume
  task automatic setCke(input logic v);
    cke = v;
  endtask : setCke
endmodule : sbit_ctrl_model

// [verif/sbit_core_tb.sv]
// self-checking bench for sbit_core, stimulus through the controller model
// assumes a 10 MHz clk and one command per edge
`timescale 1ns/10ps
module sbit_core_tb;
  localparam logic [3:0] cNop = 4'hf, cAct = 4'h3, cRd = 4'h5, cWr = 4'h4;
  localparam logic [3:0] cPre = 4'h2, cStop = 4'h6;
  logic                  clk;
  logic                  rstn;
  logic                  cke;
  sbit_pkg::sbit_cmd_s   cmdPins;
  logic [9:0]            addr;
  sbit_pkg::sbit_mask_s  byteMaskPair;
  sbit_pkg::sbit_mode_s  mode;
  logic [15:0]           dqIn;
  logic [15:0]           dqOut;
  logic [1:0]            dqOe;
  logic [1:0]            bankOpen;
  logic                  suspended;
  sbit_pkg::sbit_burst_e burstKind;
  logic [15:0]           exp40 [4] = '{16'h5555, 16'h6666, 16'h7a7a, 16'h8888};
  int                    errors;
  int                    comparisons;

  sbit_core sbit_core_i (.clk(clk), .rstn(rstn), .cke(cke), .cmdPins(cmdPins),
    .addr(addr), .byteMaskPair(byteMaskPair), .mode(mode), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .bankOpen(bankOpen), .suspended(suspended), .burstKind(burstKind));
  sbit_ctrl_model sbit_ctrl_model_i (.clk(clk), .cmdPins(cmdPins), .addr(addr),
    .byteMaskPair(byteMaskPair), .dqIn(dqIn), .cke(cke));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chkData(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chkData

  task automatic chkFlag(input string n, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chkFlag

  task automatic cmd(input logic [3:0] c, input logic [9:0] a, input logic [1:0] m);
    sbit_ctrl_model_i.send(c, a, m, 16'h0000, 1'b0);
  endtask : cmd

  task automatic dat(input logic [3:0] c, input logic [9:0] a, input logic [1:0] m,
                     input logic [15:0] d);
    sbit_ctrl_model_i.send(c, a, m, d, 1'b1);
  endtask : dat

  // output must stay driven cl-1 cycles after the command, then float
  task automatic stopChk(input logic [3:0] c, input int cl);
    cmd(c, 10'h000, 2'h0);
    repeat (cl - 2) cmd(cNop, 10'h000, 2'h0);
    chkFlag("oe held", 2'h3, dqOe);
    cmd(cNop, 10'h000, 2'h0);
    chkFlag("oe off", 2'h0, dqOe);
  endtask : stopChk

  // page content after the 257-word full-page write
  function automatic logic [15:0] fp(input logic [7:0] col);
    return (col == 8'h00) ? 16'hc100 : {8'hc0, col};
  endfunction : fp

  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    rstn = 1'b0;
    mode = '{1'b0, 1'b1, 2'h2, 1'b0};
    repeat (5) @(posedge clk);
    #1;
    chkFlag("oe reset", 2'h0, dqOe);
    chkFlag("bank reset", 2'h0, bankOpen);
    rstn = 1'b1;
    repeat (2) cmd(cNop, 10'h000, 2'h0);
    cmd(cAct, 10'h000, 2'h0);
    chkFlag("bank0 open", 2'h1, bankOpen);
    cmd(cNop, 10'h000, 2'h0);
    for (int i = 0; i <= 256; i++) begin
      dat((i == 0) ? cWr : cNop, 10'h000, 2'h0, 16'hc000 + 16'(i));
    end
    chkFlag("kind write", sbit_pkg::BURST_WRITE, burstKind);
    cmd(cStop, 10'h000, 2'h0);
    dat(cNop, 10'h000, 2'h0, 16'h1234);
    chkFlag("kind idle", sbit_pkg::BURST_IDLE, burstKind);
    cmd(cRd, 10'h0fe, 2'h0);
    for (int k = 0; k <= 256; k++) begin
      cmd(cNop, 10'h000, 2'h0);
      chkData("page read", fp(8'(8'hfe + k)), dqOut);
    end
    stopChk(cStop, 2);
    mode.fullPage = 1'b0;
    dat(cWr, 10'h010, 2'h0, 16'h1111);
    dat(cNop, 10'h000, 2'h2, 16'h2222);
    dat(cNop, 10'h000, 2'h1, 16'h3333);
    dat(cNop, 10'h000, 2'h0, 16'h4444);
    cmd(cNop, 10'h000, 2'h0);
    mode.singleWrite = 1'b1;
    dat(cWr, 10'h020, 2'h0, 16'h7777);
    repeat (3) dat(cNop, 10'h000, 2'h0, 16'h8888);
    mode.singleWrite = 1'b0;
    cmd(cAct, 10'h200, 2'h0);
    chkFlag("both open", 2'h3, bankOpen);
    dat(cWr, 10'h040, 2'h0, 16'h5555);
    dat(cNop, 10'h000, 2'h0, 16'h6666);
    dat(cPre, 10'h200, 2'h0, 16'h7a7a);
    dat(cNop, 10'h000, 2'h0, 16'h8888);
    chkFlag("bank1 closed", 2'h1, bankOpen);
    cmd(cAct, 10'h200, 2'h0);
    dat(cWr, 10'h030, 2'h0, 16'h9999);
    dat(cNop, 10'h000, 2'h0, 16'haaaa);
    cmd(cPre, 10'h300, 2'h3);
    dat(cNop, 10'h000, 2'h0, 16'hbbbb);
    chkFlag("all closed", 2'h0, bankOpen);
    cmd(cAct, 10'h000, 2'h0);
    cmd(cNop, 10'h000, 2'h0);
    cmd(cRd, 10'h010, 2'h0);
    cmd(cNop, 10'h000, 2'h1);
    chkData("mask w0", 16'h1111, dqOut);
    cmd(cNop, 10'h000, 2'h0);
    chkFlag("lower float", 2'h2, dqOe);
    chkData("upper live", 16'h00c0, {8'h00, dqOut[15:8]});
    cmd(cNop, 10'h000, 2'h0);
    chkFlag("lower back", 2'h3, dqOe);
    chkData("mask w2", 16'h3312, dqOut);
    cmd(cNop, 10'h000, 2'h0);
    chkData("mask w3", 16'h4444, dqOut);
    cmd(cRd, 10'h020, 2'h0);
    cmd(cNop, 10'h000, 2'h0);
    chkData("single w0", 16'h7777, dqOut);
    sbit_ctrl_model_i.setCke(1'b0);
    cmd(cNop, 10'h000, 2'h0);
    chkData("last live", 16'hc021, dqOut);
    cmd(cPre, 10'h000, 2'h0);
    cmd(cNop, 10'h000, 2'h0);
    chkData("held", 16'hc021, dqOut);
    chkFlag("suspended", 2'h1, suspended);
    chkFlag("pre ignored", 2'h1, bankOpen);
    sbit_ctrl_model_i.setCke(1'b1);
    cmd(cNop, 10'h000, 2'h0);
    chkData("still held", 16'hc021, dqOut);
    cmd(cNop, 10'h000, 2'h0);
    chkData("resumed", 16'hc022, dqOut);
    cmd(cRd, 10'h040, 2'h0);
    foreach (exp40[k]) begin
      cmd(cNop, 10'h000, 2'h0);
      chkData("bank0 w40", exp40[k], dqOut);
    end
    cmd(cNop, 10'h000, 2'h0);
    mode.casLat3 = 1'b1;
    mode.burstLenLog = 2'h3;
    cmd(cRd, 10'h032, 2'h0);
    repeat (2) cmd(cNop, 10'h000, 2'h0);
    chkData("cl3 w0", 16'hc032, dqOut);
    cmd(cNop, 10'h000, 2'h0);
    chkData("cl3 w1", 16'hc033, dqOut);
    stopChk(cPre, 3);
    tally_and_finish();
  end
endmodule : sbit_core_tb
